// file: acc_pkg.sv
// constants, register map and types of the calibration control block
package acc_pkg;
    localparam int unsigned ACC_DATA_W       = 32;
    localparam int unsigned ACC_REG_W        = 8;
    localparam int unsigned ACC_ADDR_W       = 12;
    // printed offsets are word indexes; byte address is four times the index
    localparam logic [9:0]  ACC_IDX_RUN      = 10'h061;
    localparam logic [9:0]  ACC_IDX_MODE     = 10'h062;
    localparam logic [9:0]  ACC_IDX_OFFSET_REFERENCE_SELECT    = 10'h065;
    localparam logic [9:0]  ACC_IDX_AVG      = 10'h068;
    localparam logic [9:0]  ACC_IDX_LINK     = 10'h069;
    localparam logic [9:0]  ACC_IDX_STATUS   = 10'h06a;
    localparam logic [7:0]  ACC_RST_RUN      = 8'h01;
    localparam logic [7:0]  ACC_RST_MODE     = 8'h01;
    localparam logic [7:0]  ACC_RST_OFFSET_REFERENCE_SELECT    = 8'h01;
    localparam logic [7:0]  ACC_RST_AVG      = 8'h61;
    localparam logic [7:0]  ACC_RST_LINK     = 8'h00;
    localparam int unsigned ACC_BIT_RUN      = 0;
    localparam int unsigned ACC_BIT_FG       = 0;
    localparam int unsigned ACC_BIT_BG       = 1;
    localparam int unsigned ACC_BIT_FGOS     = 2;
    localparam int unsigned ACC_BIT_BGOS     = 3;
    localparam int unsigned ACC_BIT_OFFSET_REFERENCE_SELECT    = 2;
    localparam int unsigned ACC_BIT_LINK     = 0;
    localparam int unsigned ACC_LIN_LSB      = 0;
    localparam int unsigned ACC_OS_LSB       = 4;
    localparam int unsigned ACC_AVG_W        = 3;
    localparam int unsigned ACC_CNT_W        = 16;
    localparam logic [15:0] ACC_LIN_BASE     = 16'h0010;
    localparam logic [15:0] ACC_OS_BASE      = 16'h0008;
    localparam logic [15:0] ACC_CNT_ONE      = 16'h0001;
    localparam logic [15:0] ACC_CNT_ZERO     = 16'h0000;

    typedef enum logic [2:0] {
        ACC_HOLD   = 3'b000,
        ACC_CLEAR  = 3'b001,
        ACC_FG_LIN = 3'b011,
        ACC_FG_OS  = 3'b010,
        ACC_BG     = 3'b110,
        ACC_DONE   = 3'b111
    } acc_state_t;
endpackage

// file: acc_top.sv
// calibration run control, mode registers and sequencing engine behind apb
`timescale 1ns/100ps
// Operation
// - run bit high lets the engine run; low holds it in reset.
// - run bit low also resets digital and serial link clock dividers.
// - foreground select clears calibration values; 1 runs foreground, 0 skips.
// - background select enables background calibration.
// - background offset calibration acts only while background is enabled.
// - foreground offset calibration acts only while foreground is selected.
// - reference select 0 calibrates offset to mid-code.
// - reference select 1 matches offsets to spare converter, background only.
// - offset averaging field sets offset step length; larger is longer.
// - linearity averaging field sets linearity step length; larger is longer.
// - foreground complete flag rises when foreground finishes or is skipped.
module acc_top
    import acc_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ACC_ADDR_W-1:0] paddr,
    input  wire logic [ACC_DATA_W-1:0] pwdata,
    output logic      [ACC_DATA_W-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic                       cal_engine_reset_n,
    output logic                       digital_divider_reset,
    output logic                       link_divider_reset,
    output logic                       serial_link_enable,
    output logic                       cal_values_clear,
    output logic                       foreground_cal_active,
    output logic                       foreground_offset_active,
    output logic                       background_cal_active,
    output logic                       background_offset_active,
    output logic                       offset_ref_spare,
    output logic                       foreground_complete_flag,
    output logic      [ACC_AVG_W-1:0]  linearity_averaging_depth,
    output logic      [ACC_AVG_W-1:0]  offset_averaging_depth
);
    logic [ACC_REG_W-1:0]  calibration_run_control;
    logic [ACC_REG_W-1:0]  calibration_mode_config;
    logic [ACC_REG_W-1:0]  offset_reference_config;
    logic [ACC_REG_W-1:0]  calibration_averaging;
    logic [ACC_REG_W-1:0]  serial_link_control;
    logic [ACC_REG_W-1:0]  next_run;
    logic [ACC_REG_W-1:0]  next_mode;
    logic [ACC_REG_W-1:0]  next_offset_reference_select;
    logic [ACC_REG_W-1:0]  next_avg;
    logic [ACC_REG_W-1:0]  next_link;
    logic [ACC_DATA_W-1:0] next_prdata;
    logic                  next_pready;
    logic                  next_pslverr;
    logic [9:0]            word_idx;
    logic                  access;
    logic                  mapped;
    logic [ACC_REG_W-1:0]  read_val;
    logic [ACC_REG_W-1:0]  status_val;

    acc_state_t            state;
    acc_state_t            next_state;
    logic [ACC_CNT_W-1:0]  count;
    logic [ACC_CNT_W-1:0]  next_count;
    logic                  run_prev;
    logic                  next_run_prev;
    logic                  next_foreground_complete_flag;
    logic                  run_bit;
    logic                  fg_sel;
    logic                  bg_sel;
    logic [ACC_AVG_W-1:0]  lin_depth;
    logic [ACC_AVG_W-1:0]  os_depth;
    logic                  wr_strobe;

    // next values of the registered outputs
    logic                  next_cal_engine_reset_n;
    logic                  next_digital_divider_reset;
    logic                  next_link_divider_reset;
    logic                  next_serial_link_enable;
    logic                  next_cal_values_clear;
    logic                  next_foreground_cal_active;
    logic                  next_foreground_offset_active;
    logic                  next_background_cal_active;
    logic                  next_background_offset_active;
    logic                  next_offset_ref_spare;
    logic [ACC_AVG_W-1:0]  next_linearity_averaging_depth;
    logic [ACC_AVG_W-1:0]  next_offset_averaging_depth;

    // cycles of one averaging step: base doubled per depth code
    function automatic logic [ACC_CNT_W-1:0] acc_avg_cycles(
        input logic [ACC_CNT_W-1:0] base,
        input logic [ACC_AVG_W-1:0] depth
    );
        acc_avg_cycles = base << depth;
    endfunction

    // state after the foreground steps: background if selected, else done
    function automatic acc_state_t after_foreground(input logic bg);
        after_foreground = bg ? ACC_BG : ACC_DONE;
    endfunction

    assign word_idx   = paddr[ACC_ADDR_W-1:2];
    assign access     = psel && penable && !pready;
    // write lands at the edge that completes the access phase
    assign wr_strobe  = psel && penable && pready && pwrite && !pslverr;
    assign run_bit    = calibration_run_control[ACC_BIT_RUN];
    assign fg_sel     = calibration_mode_config[ACC_BIT_FG];
    assign bg_sel     = calibration_mode_config[ACC_BIT_BG];
    assign lin_depth  = calibration_averaging[ACC_LIN_LSB +: ACC_AVG_W];
    assign os_depth   = calibration_averaging[ACC_OS_LSB +: ACC_AVG_W];
    assign status_val = {3'b000, background_cal_active, state, foreground_complete_flag};

    // register file and apb slave, one wait state per access
    always_comb begin
        next_run     = calibration_run_control;
        next_mode    = calibration_mode_config;
        next_offset_reference_select   = offset_reference_config;
        next_avg     = calibration_averaging;
        next_link    = serial_link_control;
        next_prdata  = prdata;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        mapped       = 1'b1;
        read_val     = 8'h00;
        if (word_idx == ACC_IDX_RUN) begin
            read_val = calibration_run_control;
        end else if (word_idx == ACC_IDX_MODE) begin
            read_val = calibration_mode_config;
        end else if (word_idx == ACC_IDX_OFFSET_REFERENCE_SELECT) begin
            read_val = offset_reference_config;
        end else if (word_idx == ACC_IDX_AVG) begin
            read_val = calibration_averaging;
        end else if (word_idx == ACC_IDX_LINK) begin
            read_val = serial_link_control;
        end else if (word_idx == ACC_IDX_STATUS) begin
            read_val = status_val;
        end else begin
            mapped = 1'b0;
        end
        if (access) begin
            next_pready  = 1'b1;
            next_pslverr = !mapped;
            next_prdata  = {24'h00_0000, read_val};
        end
        // full byte stored so reserved fields keep what was written
        if (wr_strobe) begin
            if (word_idx == ACC_IDX_RUN) begin
                next_run = pwdata[ACC_REG_W-1:0];
            end else if (word_idx == ACC_IDX_MODE) begin
                next_mode = pwdata[ACC_REG_W-1:0];
            end else if (word_idx == ACC_IDX_OFFSET_REFERENCE_SELECT) begin
                next_offset_reference_select = pwdata[ACC_REG_W-1:0];
            end else if (word_idx == ACC_IDX_AVG) begin
                next_avg = pwdata[ACC_REG_W-1:0];
            end else if (word_idx == ACC_IDX_LINK) begin
                next_link = pwdata[ACC_REG_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            calibration_run_control <= ACC_RST_RUN;
            calibration_mode_config <= ACC_RST_MODE;
            offset_reference_config <= ACC_RST_OFFSET_REFERENCE_SELECT;
            calibration_averaging   <= ACC_RST_AVG;
            serial_link_control     <= ACC_RST_LINK;
            prdata                  <= 32'h0000_0000;
            pready                  <= 1'b0;
            pslverr                 <= 1'b0;
        end else begin
            calibration_run_control <= next_run;
            calibration_mode_config <= next_mode;
            offset_reference_config <= next_offset_reference_select;
            calibration_averaging   <= next_avg;
            serial_link_control     <= next_link;
            prdata                  <= next_prdata;
            pready                  <= next_pready;
            pslverr                 <= next_pslverr;
        end
    end

    // calibration sequencing engine
    always_comb begin
        next_state    = state;
        next_count    = count;
        next_run_prev = run_bit;
        next_foreground_complete_flag  = foreground_complete_flag;
        if (!run_bit) begin
            next_state   = ACC_HOLD;
            next_count   = ACC_CNT_ZERO;
            next_foreground_complete_flag = 1'b0;
        end else begin
            case (state)
                ACC_HOLD: begin
                    if (!run_prev) begin
                        next_state = ACC_CLEAR;
                    end
                end
                ACC_CLEAR: begin
                    // values cleared either way; then foreground or skip
                    if (fg_sel) begin
                        next_state = ACC_FG_LIN;
                        next_count = acc_avg_cycles(ACC_LIN_BASE, lin_depth);
                    end else begin
                        next_state   = after_foreground(bg_sel);
                        next_foreground_complete_flag = 1'b1;
                    end
                end
                ACC_FG_LIN: begin
                    if (count > ACC_CNT_ONE) begin
                        next_count = count - ACC_CNT_ONE;
                    end else if (calibration_mode_config[ACC_BIT_FGOS]) begin
                        next_state = ACC_FG_OS;
                        next_count = acc_avg_cycles(ACC_OS_BASE, os_depth);
                    end else begin
                        next_state   = after_foreground(bg_sel);
                        next_foreground_complete_flag = 1'b1;
                    end
                end
                ACC_FG_OS: begin
                    if (count > ACC_CNT_ONE) begin
                        next_count = count - ACC_CNT_ONE;
                    end else begin
                        next_state   = after_foreground(bg_sel);
                        next_foreground_complete_flag = 1'b1;
                    end
                end
                ACC_BG: begin
                    if (!bg_sel) begin
                        next_state = ACC_DONE;
                    end
                end
                ACC_DONE: begin
                    if (bg_sel) begin
                        next_state = ACC_BG;
                    end
                end
                default: begin
                    next_state = ACC_HOLD;
                end
            endcase
        end
        // outputs follow the new register and state values at the same edge
        next_cal_engine_reset_n        = next_run[ACC_BIT_RUN];
        next_digital_divider_reset     = !next_run[ACC_BIT_RUN];
        next_link_divider_reset        = !next_run[ACC_BIT_RUN];
        next_serial_link_enable        = next_link[ACC_BIT_LINK];
        next_cal_values_clear          = (next_state == ACC_CLEAR);
        next_foreground_cal_active     = (next_state == ACC_FG_LIN);
        next_foreground_offset_active  = (next_state == ACC_FG_OS);
        next_background_cal_active     = (next_state == ACC_BG);
        next_background_offset_active  = (next_state == ACC_BG) &&
                                         next_mode[ACC_BIT_BGOS];
        // spare reference only honoured with background on, else mid-code
        next_offset_ref_spare          = next_offset_reference_select[ACC_BIT_OFFSET_REFERENCE_SELECT] &&
                                         next_mode[ACC_BIT_BG];
        next_linearity_averaging_depth = next_avg[ACC_LIN_LSB +: ACC_AVG_W];
        next_offset_averaging_depth    = next_avg[ACC_OS_LSB +: ACC_AVG_W];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state                     <= ACC_HOLD;
            count                     <= ACC_CNT_ZERO;
            run_prev                  <= 1'b0;
            foreground_complete_flag  <= 1'b0;
            cal_engine_reset_n        <= 1'b0;
            digital_divider_reset     <= 1'b1;
            link_divider_reset        <= 1'b1;
            serial_link_enable        <= 1'b0;
            cal_values_clear          <= 1'b0;
            foreground_cal_active     <= 1'b0;
            foreground_offset_active  <= 1'b0;
            background_cal_active     <= 1'b0;
            background_offset_active  <= 1'b0;
            offset_ref_spare          <= 1'b0;
            linearity_averaging_depth <= ACC_RST_AVG[ACC_LIN_LSB +: ACC_AVG_W];
            offset_averaging_depth    <= ACC_RST_AVG[ACC_OS_LSB +: ACC_AVG_W];
        end else begin
            state                     <= next_state;
            count                     <= next_count;
            run_prev                  <= next_run_prev;
            foreground_complete_flag  <= next_foreground_complete_flag;
            cal_engine_reset_n        <= next_cal_engine_reset_n;
            digital_divider_reset     <= next_digital_divider_reset;
            link_divider_reset        <= next_link_divider_reset;
            serial_link_enable        <= next_serial_link_enable;
            cal_values_clear          <= next_cal_values_clear;
            foreground_cal_active     <= next_foreground_cal_active;
            foreground_offset_active  <= next_foreground_offset_active;
            background_cal_active     <= next_background_cal_active;
            background_offset_active  <= next_background_offset_active;
            offset_ref_spare          <= next_offset_ref_spare;
            linearity_averaging_depth <= next_linearity_averaging_depth;
            offset_averaging_depth    <= next_offset_averaging_depth;
        end
    end
endmodule

// file: acc_top_monitor.sv
// concurrent checks on the calibration control block ports
`timescale 1ns/100ps
module acc_top_monitor import acc_pkg::*; (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  pwrite,
    input wire logic [ACC_ADDR_W-1:0] paddr,
    input wire logic [ACC_DATA_W-1:0] pwdata,
    input wire logic                  pready,
    input wire logic                  cal_engine_reset_n,
    input wire logic                  link_divider_reset,
    input wire logic                  cal_values_clear,
    input wire logic                  foreground_cal_active,
    input wire logic                  foreground_offset_active,
    input wire logic                  background_offset_active,
    input wire logic                  offset_ref_spare,
    input wire logic                  foreground_complete_flag
);
    logic       wr_acc;
    logic [7:0] mode_q, next_mode_q;
    assign wr_acc = psel && pready && pwrite;
    // shadow of the mode register, for gating checks
    assign next_mode_q = (wr_acc && paddr[11:2] == ACC_IDX_MODE) ? pwdata[7:0] : mode_q;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) mode_q <= 8'h01;
        else mode_q <= next_mode_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_run_low: assert property (wr_acc && paddr[11:2] == ACC_IDX_RUN && !pwdata[0]
        |=> ##[0:1] (!cal_engine_reset_n && link_divider_reset)) else $error("engine not held");
    chk_clear_pulse: assert property (cal_values_clear
        |=> !cal_values_clear) else $error("clear pulse too long");
    chk_seq_start: assert property ($rose(cal_engine_reset_n)
        |-> ##[0:3] cal_values_clear) else $error("no clear at sequence start");
    chk_fg_os_sel: assert property (foreground_offset_active
        |-> mode_q[0] && mode_q[2]) else $error("offset step without selection");
    chk_bg_os_sel: assert property (background_offset_active
        |-> mode_q[1] && mode_q[3]) else $error("background offset without selection");
    chk_spare_bg: assert property (offset_ref_spare
        |-> mode_q[1]) else $error("spare reference without background");
    chk_flag_clear: assert property ($fell(cal_engine_reset_n)
        |-> ##[0:1] !foreground_complete_flag) else $error("flag not cleared");
    chk_flag_fg: assert property (foreground_complete_flag
        |-> !foreground_cal_active && !foreground_offset_active) else $error("flag too early");
    cover property ($rose(foreground_offset_active));
    cover property ($rose(background_offset_active));
    cover property ($fell(cal_engine_reset_n));
endmodule

bind acc_top acc_top_monitor acc_top_monitor_inst (.pclk, .presetn, .psel, .pwrite, .paddr,
    .pwdata, .pready, .cal_engine_reset_n, .link_divider_reset, .cal_values_clear,
    .foreground_cal_active, .foreground_offset_active, .background_offset_active,
    .offset_ref_spare, .foreground_complete_flag);

// file: test_acc_top.sv
// self-checking testbench of the calibration control block over apb
`timescale 1ns/100ps
module test_acc_top import acc_pkg::*;;
    logic                  pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic                  pwrite = 1'b0, pready, pslverr, err;
    logic [ACC_ADDR_W-1:0] paddr = '0;
    logic [ACC_DATA_W-1:0] pwdata = '0, prdata, rd;
    logic                  cal_engine_reset_n, digital_divider_reset, link_divider_reset;
    logic                  serial_link_enable, cal_values_clear, foreground_cal_active;
    logic                  foreground_offset_active, background_cal_active, offset_ref_spare;
    logic                  background_offset_active, foreground_complete_flag;
    logic [ACC_AVG_W-1:0]  linearity_averaging_depth, offset_averaging_depth;
    int                    mismatches = 0, checks = 0, lin_n, os_n;
    acc_top acc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .cal_engine_reset_n, .digital_divider_reset, .link_divider_reset,
        .serial_link_enable, .cal_values_clear, .foreground_cal_active, .foreground_offset_active,
        .background_cal_active, .background_offset_active, .offset_ref_spare,
        .foreground_complete_flag, .linearity_averaging_depth, .offset_averaging_depth);
    always #50 pclk = ~pclk;
    task automatic results();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check_word(input logic [32:0] got, input logic [32:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (t = 0; t < 20; t++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (t == 20) begin
            mismatches++;
            $display("CHECK FAILED at %0t: no bus answer", $time);
            results();
        end
    endtask
    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp, input logic exp_err);
        xfer(1'b0, idx, 32'h0000_0000);
        check_word({err, rd}, {exp_err, exp});
    endtask
    // counts cycles of each foreground step until the complete flag rises
    task automatic measure(input logic [32:0] exp_lin, input logic [32:0] exp_os);
        int t;
        lin_n = 0;
        os_n = 0;
        for (t = 0; t < 5000 && foreground_complete_flag !== 1'b1; t++) begin
            @(posedge pclk);
            if (foreground_cal_active === 1'b1) lin_n++;
            if (foreground_offset_active === 1'b1) os_n++;
        end
        if (t == 5000) begin
            mismatches++;
            $display("CHECK FAILED at %0t: foreground never completed", $time);
            results();
        end
        check_word(lin_n, exp_lin);
        check_word(os_n, exp_os);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        measure(32'(ACC_LIN_BASE) << 1, 0);
        check_word({linearity_averaging_depth, offset_averaging_depth}, 6'h0e);
        rd_chk(ACC_IDX_RUN, 32'h0000_0001, 1'b0);
        rd_chk(ACC_IDX_MODE, 32'h0000_0001, 1'b0);
        rd_chk(ACC_IDX_OFFSET_REFERENCE_SELECT, 32'h0000_0001, 1'b0);
        rd_chk(ACC_IDX_AVG, 32'h0000_0061, 1'b0);
        rd_chk(ACC_IDX_STATUS, 32'h0000_000f, 1'b0);
        xfer(1'b1, ACC_IDX_LINK, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        check_word(serial_link_enable, 1'b1);
        xfer(1'b1, ACC_IDX_LINK, 32'h0000_0000);
        xfer(1'b1, ACC_IDX_RUN, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        check_word({cal_engine_reset_n, foreground_complete_flag}, 2'h0);
        check_word({digital_divider_reset, link_divider_reset}, 2'h3);
        xfer(1'b1, ACC_IDX_MODE, 32'h0000_0005);
        xfer(1'b1, ACC_IDX_AVG, 32'h0000_0032);
        xfer(1'b1, ACC_IDX_RUN, 32'h0000_0001);
        measure(32'(ACC_LIN_BASE) << 2, 32'(ACC_OS_BASE) << 3);
        check_word(background_cal_active, 1'b0);
        xfer(1'b1, ACC_IDX_RUN, 32'h0000_0000);
        xfer(1'b1, ACC_IDX_MODE, 32'h0000_000a);
        xfer(1'b1, ACC_IDX_OFFSET_REFERENCE_SELECT, 32'h0000_0005);
        repeat (2) @(posedge pclk);
        check_word(offset_ref_spare, 1'b1);
        xfer(1'b1, ACC_IDX_RUN, 32'h0000_0001);
        measure(0, 0);
        repeat (2) @(posedge pclk);
        check_word({background_cal_active, background_offset_active}, 2'h3);
        xfer(1'b1, ACC_IDX_RUN, 32'h0000_0000);
        xfer(1'b1, ACC_IDX_OFFSET_REFERENCE_SELECT, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        check_word({offset_ref_spare, background_cal_active}, 2'h0);
        rd_chk(ACC_IDX_MODE, 32'h0000_000a, 1'b0);
        rd_chk(ACC_IDX_OFFSET_REFERENCE_SELECT, 32'h0000_0001, 1'b0);
        rd_chk(10'h070, 32'h0000_0000, 1'b1);
        results();
    end
endmodule
